// ===== verilog/flash_self_program_ctrl.sv
`timescale 1ns/1ps
// Function
// - code protection blocks external programmer access, never self-write or row erase
// - only external bulk erase clears protection, along with all memory and settings
// - guard range field selects region where self-write and self-erase are refused
// - array stores 14-bit words, plus identification and configuration words
// - erase sets every bit to one; programming only clears bits
// - rows are 32 words; a row is the smallest erasable unit
// - row data staged in hidden 14-bit latches filled through the word pair
// - whole or partial rows may be programmed; erased words need no erase
// - bulk erase unavailable to software; only row erase and write
// - indirect read returns one byte in one cycle, cpu stalled meanwhile
// - indirect path and instruction fetch are read-only
// - registers read/write program and user id words, read-only id and configuration
// - register erase or write suppressed on guarded addresses
// - read stalls cpu; word lands in data pair two cycles after the strobe write
// - data pair holds word until next read or software write
// - hardware clears read strobe when read completes
// - write and erase durations come from an internal timer
// - erase on guarded address clears program strobe and is skipped
// - completion sets done flag; interrupt raised when enable is set
// - cpu stalls from program strobe until the operation completes
module flash_self_program_ctrl #(
    parameter int unsigned PROG_WAIT_CYCLES = flash_self_program_pkg::PROG_CYCLES,
    parameter logic [13:0] DEVICE_CODE      = 14'h0123, // arbitrary value
    parameter logic [13:0] REVISION_CODE    = 14'h0001  // arbitrary value
) (
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        code_protect_n_in,
    input  wire logic [1:0]  self_update_guard_range_in,
    input  wire logic [flash_self_program_pkg::PFM_AW-1:0] fetch_addr_in,
    output logic      [13:0] fetch_word_out,
    input  wire logic        ind_req_in,
    input  wire logic [flash_self_program_pkg::PFM_AW-1:0] ind_addr_in,
    output logic      [7:0]  ind_byte_out,
    output logic             ind_valid_out,
    output logic             cpu_stall_out,
    output logic             flash_done_irq_out,
    output logic             ext_access_block_out
);
    import flash_self_program_pkg::*;

    localparam int TMR_W = $clog2(PROG_WAIT_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(PROG_WAIT_CYCLES - 1);

    seq_state_t  state_ff, nxt_state;
    key_state_t  key_ff;
    arr_req_t    arr_req;
    logic [2:0]  cfg_meta_ff, cfg_sync_ff;
    logic        ph_wr_ff;
    logic [7:0]  ph_addr_ff;
    logic        rd_ff, wr_ff, modify_enable_ff, free_ff, load_only_ff, space_select_ff;
    logic        flash_done_flag_ff, flash_done_irq_enable_ff;
    logic [7:0]  addr_lo_ff, word_lo_ff;
    logic [6:0]  addr_hi_ff;
    logic [5:0]  word_hi_ff;
    logic [TMR_W-1:0] tmr_ff;
    logic [4:0]  idx_ff;
    logic [13:0] latch_mem [ROW_WORDS];
    logic [31:0] latch_valid_ff;
    logic [31:0] hrdata_ff, rd_mux;
    logic [13:0] fetch_word_ff, arr_word, rd_word, fetch_word;
    logic [7:0]  ind_byte_ff;
    logic        ind_valid_ff, stall_ff, irq_ff, block_ff;
    logic        take, wr_ctrl, wr_key, busy, guarded, ctrl_ok, rd_go, wr_req;
    logic        load_go, erase_go, prog_go, ind_take, op_end, nxt_done;
    logic [14:0] flash_addr;
    logic        cp_n_sync;
    logic [1:0]  guard_sync;

    // refusal region for self-writes; external programmer is not limited by it
    function automatic logic is_guarded(input logic space, input logic [14:0] a, input logic [1:0] g);
        if (space) begin
            is_guarded = (a >= 15'(ID_WRITABLE));
        end else begin
            case (g)
                GUARD_ALL:  is_guarded = 1'b1;
                GUARD_HALF: is_guarded = (a[12:0] < HALF_LIMIT);
                GUARD_BOOT: is_guarded = (a[12:0] < BOOT_LIMIT);
                default:    is_guarded = 1'b0;
            endcase
        end
    endfunction

    // configuration fuses come from outside the clock domain
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_meta_ff <= CFG_RESET;
            cfg_sync_ff <= CFG_RESET;
        end else begin
            cfg_meta_ff <= {self_update_guard_range_in, code_protect_n_in};
            cfg_sync_ff <= cfg_meta_ff;
        end
    end
    assign cp_n_sync  = cfg_sync_ff[0];
    assign guard_sync = cfg_sync_ff[2:1];

    // ahb address phase: only whole-word transfers are taken
    assign take = hsel_in & htrans_in[1] & hready_in & (hsize_in == HSIZE_WORD);
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ph_wr_ff   <= 1'b0;
            ph_addr_ff <= 8'h00;
        end else begin
            ph_wr_ff <= take & hwrite_in;
            if (take) begin
                ph_addr_ff <= haddr_in[7:0];
            end
        end
    end

    assign wr_ctrl    = ph_wr_ff && (ph_addr_ff == OFS_CTRL);
    assign wr_key     = ph_wr_ff && (ph_addr_ff == OFS_KEY);
    assign busy       = (state_ff != ST_IDLE);
    assign flash_addr = {addr_hi_ff, addr_lo_ff};
    assign guarded    = is_guarded(hwdata_in[CTRL_SPACE_BIT], flash_addr, guard_sync);
    assign ctrl_ok    = wr_ctrl & ~busy;
    assign rd_go      = ctrl_ok & hwdata_in[CTRL_RD_BIT];
    assign wr_req     = ctrl_ok & ~hwdata_in[CTRL_RD_BIT] & hwdata_in[CTRL_WR_BIT]
                        & hwdata_in[CTRL_MODIFY_ENABLE_BIT] & (key_ff == KEY_OPEN);
    assign load_go    = wr_req & hwdata_in[CTRL_LOAD_BIT];
    assign erase_go   = wr_req & ~hwdata_in[CTRL_LOAD_BIT] & hwdata_in[CTRL_FREE_BIT] & ~guarded;
    assign prog_go    = wr_req & ~hwdata_in[CTRL_LOAD_BIT] & ~hwdata_in[CTRL_FREE_BIT] & ~guarded;
    assign ind_take   = ind_req_in & ~busy & ~ph_wr_ff;
    assign op_end     = (state_ff == ST_WAIT) && (tmr_ff == '0);
    assign nxt_done   = op_end | flash_done_flag_ff & ~(ctrl_ok & ~hwdata_in[CTRL_DONE_BIT]);

    // unlock: 55h then AAh then the strobe, any other write in between disarms
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            key_ff <= KEY_IDLE;
        end else if (ph_wr_ff) begin
            if (wr_key && hwdata_in[7:0] == KEY_FIRST) begin
                key_ff <= KEY_HALF;
            end else if (wr_key && hwdata_in[7:0] == KEY_SECOND && key_ff == KEY_HALF) begin
                key_ff <= KEY_OPEN;
            end else begin
                key_ff <= KEY_IDLE;
            end
        end
    end

    // sequencer next state; only row erase and write exist, no bulk erase
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (rd_go) begin
                    nxt_state = ST_READ;
                end else if (erase_go) begin
                    nxt_state = ST_ERASE;
                end else if (prog_go) begin
                    nxt_state = ST_PROG;
                end
            end
            ST_READ:  nxt_state = ST_IDLE;
            ST_ERASE: nxt_state = ST_WAIT;
            ST_PROG:  nxt_state = (idx_ff == 5'h1F) ? ST_WAIT : ST_PROG;
            ST_WAIT:  nxt_state = op_end ? ST_IDLE : ST_WAIT;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    // sequencer, latch walk index and internal write timer
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= ST_IDLE;
            idx_ff   <= 5'h00;
            tmr_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            idx_ff   <= (state_ff == ST_PROG) ? idx_ff + 5'h01 : 5'h00;
            if (nxt_state == ST_WAIT && state_ff != ST_WAIT) begin
                tmr_ff <= TMR_LOAD;
            end else if (state_ff == ST_WAIT) begin
                tmr_ff <= tmr_ff - 1'b1;
            end
        end
    end

    // flash_ctrl_one; writes during an operation are dropped whole
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_ff                    <= 1'b0;
            wr_ff                    <= 1'b0;
            modify_enable_ff         <= 1'b0;
            free_ff                  <= 1'b0;
            load_only_ff             <= 1'b0;
            space_select_ff          <= 1'b0;
            flash_done_irq_enable_ff <= 1'b0;
        end else if (ctrl_ok) begin
            rd_ff                    <= rd_go;
            wr_ff                    <= erase_go | prog_go;
            modify_enable_ff         <= hwdata_in[CTRL_MODIFY_ENABLE_BIT];
            free_ff                  <= hwdata_in[CTRL_FREE_BIT];
            load_only_ff             <= hwdata_in[CTRL_LOAD_BIT];
            space_select_ff          <= hwdata_in[CTRL_SPACE_BIT];
            flash_done_irq_enable_ff <= hwdata_in[CTRL_IE_BIT];
        end else begin
            if (state_ff == ST_READ) begin
                rd_ff <= 1'b0;
            end
            if (op_end) begin
                wr_ff <= 1'b0;
            end
        end
    end

    // done flag: completion wins over a software clear in the same cycle
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flash_done_flag_ff <= 1'b0;
        end else begin
            flash_done_flag_ff <= nxt_done;
        end
    end

    // address pair
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_lo_ff <= 8'h00;
            addr_hi_ff <= 7'h00;
        end else begin
            if (ph_wr_ff && ph_addr_ff == OFS_ADDR_LO) begin
                addr_lo_ff <= hwdata_in[7:0];
            end
            if (ph_wr_ff && ph_addr_ff == OFS_ADDR_HI) begin
                addr_hi_ff <= hwdata_in[6:0];
            end
        end
    end

    // data pair keeps the last read word until reread or overwritten
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            word_lo_ff <= 8'h00;
            word_hi_ff <= 6'h00;
        end else if (state_ff == ST_READ) begin
            {word_hi_ff, word_lo_ff} <= rd_word;
        end else begin
            if (ph_wr_ff && ph_addr_ff == OFS_WORD_LO) begin
                word_lo_ff <= hwdata_in[7:0];
            end
            if (ph_wr_ff && ph_addr_ff == OFS_WORD_HI) begin
                word_hi_ff <= hwdata_in[5:0];
            end
        end
    end

    // hidden row latches: loaded from the data pair, drained and reerased by the write walk
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            latch_valid_ff <= 32'h0000_0000;
            for (int i = 0; i < ROW_WORDS; i++) begin
                latch_mem[i] <= ERASED_WORD;
            end
        end else if (load_go) begin
            latch_mem[flash_addr[4:0]]      <= {word_hi_ff, word_lo_ff};
            latch_valid_ff[flash_addr[4:0]] <= 1'b1;
        end else if (state_ff == ST_PROG) begin
            latch_mem[idx_ff]      <= ERASED_WORD;
            latch_valid_ff[idx_ff] <= 1'b0;
        end
    end

    // array port; the indirect path only ever reads, so it cannot alter memory
    always_comb begin
        arr_req       = '0;
        arr_req.addr  = flash_addr[12:0];
        arr_req.space = space_select_ff;
        case (state_ff)
            ST_ERASE: arr_req.erase = 1'b1;
            ST_PROG: begin
                arr_req.addr  = {flash_addr[12:5], idx_ff};
                arr_req.prog  = latch_valid_ff[idx_ff];
                arr_req.wdata = latch_mem[idx_ff];
            end
            ST_IDLE: begin
                if (ind_take) begin
                    arr_req.addr  = ind_addr_in;
                    arr_req.space = 1'b0;
                end
            end
            default: arr_req.erase = 1'b0;
        endcase
    end

    flash_array u_array (
        .sys_clk_in     (sys_clk_in),
        .req_in         (arr_req),
        .fetch_addr_in  (fetch_addr_in),
        .rd_word_out    (arr_word),
        .fetch_word_out (fetch_word)
    );

    // identification space above the user words is read-only
    always_comb begin
        rd_word = arr_word;
        if (arr_req.space && arr_req.addr >= 13'(ID_WRITABLE)) begin
            case (arr_req.addr[4:0])
                ID_REV_IDX: rd_word = REVISION_CODE;
                ID_DEV_IDX: rd_word = DEVICE_CODE;
                ID_CFG_IDX: rd_word = {11'h7FF, guard_sync, cp_n_sync};
                default:    rd_word = ERASED_WORD;
            endcase
        end
    end

    // register read mux, sampled in the address phase
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr_in[7:0])
            OFS_CTRL:    rd_mux = {23'h0, flash_done_irq_enable_ff, flash_done_flag_ff, space_select_ff, 1'b0,
                                   load_only_ff, free_ff, modify_enable_ff, wr_ff, rd_ff};
            OFS_ADDR_LO: rd_mux = {24'h0, addr_lo_ff};
            OFS_ADDR_HI: rd_mux = {25'h0, addr_hi_ff};
            OFS_WORD_LO: rd_mux = {24'h0, word_lo_ff};
            OFS_WORD_HI: rd_mux = {26'h0, word_hi_ff};
            OFS_CFG:     rd_mux = {28'h0, busy, guard_sync, cp_n_sync};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    // cpu-facing outputs, all registered except the constant hreadyout_out and hresp_out
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hrdata_ff     <= 32'h0000_0000;
            fetch_word_ff <= ERASED_WORD;
            ind_byte_ff   <= 8'h00;
            ind_valid_ff  <= 1'b0;
            stall_ff      <= 1'b0;
            irq_ff        <= 1'b0;
            block_ff      <= 1'b0;
        end else begin
            if (take && !hwrite_in) begin
                hrdata_ff <= rd_mux;
            end
            fetch_word_ff <= fetch_word;
            ind_valid_ff  <= ind_take;
            if (ind_take) begin
                ind_byte_ff <= rd_word[7:0];
            end
            stall_ff <= (nxt_state != ST_IDLE) | ind_take;
            irq_ff   <= nxt_done & flash_done_irq_enable_ff;
            block_ff <= ~cp_n_sync;
        end
    end

    assign hrdata_out           = hrdata_ff;
    assign hreadyout_out        = 1'b1;
    assign hresp_out            = 1'b0;
    assign fetch_word_out       = fetch_word_ff;
    assign ind_byte_out         = ind_byte_ff;
    assign ind_valid_out        = ind_valid_ff;
    assign cpu_stall_out        = stall_ff;
    assign flash_done_irq_out   = irq_ff;
    assign ext_access_block_out = block_ff;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    a_read_strobe_clear: assert property (state_ff == ST_READ |=> !rd_ff && state_ff == ST_IDLE)
        else $error("read strobe not cleared");
    a_read_word_next: assert property (rd_go |=> ##1 {word_hi_ff, word_lo_ff} == $past(rd_word))
        else $error("read word not in data pair");
    a_erase_unguarded: assert property (erase_go |=> state_ff == ST_ERASE ##1 state_ff == ST_WAIT)
        else $error("erase did not start");
    a_guarded_skip: assert property (wr_req && guarded && !hwdata_in[CTRL_LOAD_BIT] |=> !wr_ff && !busy)
        else $error("guarded request not skipped");
    a_timer_load: assert property (state_ff == ST_ERASE |=> tmr_ff == TMR_LOAD)
        else $error("write timer not loaded");
    a_done_on_end: assert property (op_end |=> flash_done_flag_ff && !wr_ff && state_ff == ST_IDLE)
        else $error("done flag missing");
    a_stall_busy: assert property (busy |-> stall_ff)
        else $error("cpu not stalled");
    a_ind_one_cycle: assert property (ind_take |=> ind_valid_ff && stall_ff
        && ind_byte_ff == $past(rd_word[7:0])) else $error("indirect read wrong");
    a_busy_ignores: assert property (busy && wr_ctrl |=> $stable(space_select_ff) && !rd_ff)
        else $error("request taken while busy");
    a_row_walk: assert property (arr_req.prog |-> state_ff == ST_PROG && latch_valid_ff[idx_ff])
        else $error("program outside row walk");

    c_read: cover property (rd_go ##2 state_ff == ST_IDLE);
    c_erase: cover property (erase_go ##[1:8] state_ff == ST_WAIT);
    c_prog: cover property (arr_req.prog);
    c_ind: cover property (ind_take ##1 ind_valid_ff);
endmodule

// ===== verilog/flash_self_program_pkg.sv
package flash_self_program_pkg;
    // timing
    localparam int CLK_MHZ      = 250;
    localparam int PROG_TIME_US = 2000;
    localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

    // array geometry
    localparam int WORD_W      = 14;
    localparam int ROW_WORDS   = 32;
    localparam int PFM_WORDS   = 8192;
    localparam int PFM_AW      = 13;
    localparam int ID_WRITABLE = 4;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_KEY     = 8'h04;
    localparam logic [7:0] OFS_ADDR_LO = 8'h08;
    localparam logic [7:0] OFS_ADDR_HI = 8'h0C;
    localparam logic [7:0] OFS_WORD_LO = 8'h10;
    localparam logic [7:0] OFS_WORD_HI = 8'h14;
    localparam logic [7:0] OFS_CFG     = 8'h18;
    localparam logic [2:0] HSIZE_WORD  = 3'h2;

    // unlock key bytes
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // flash_ctrl_one field positions
    localparam int CTRL_RD_BIT    = 0;
    localparam int CTRL_WR_BIT    = 1;
    localparam int CTRL_MODIFY_ENABLE_BIT  = 2;
    localparam int CTRL_FREE_BIT  = 3;
    localparam int CTRL_LOAD_BIT  = 4;
    localparam int CTRL_SPACE_BIT = 6;
    localparam int CTRL_DONE_BIT  = 7;
    localparam int CTRL_IE_BIT    = 8;

    // read-only words of the identification space
    localparam logic [4:0] ID_REV_IDX = 5'h05;
    localparam logic [4:0] ID_DEV_IDX = 5'h06;
    localparam logic [4:0] ID_CFG_IDX = 5'h07;

    // self_update_guard_range encodings and limits
    localparam logic [1:0]  GUARD_ALL  = 2'h0;
    localparam logic [1:0]  GUARD_HALF = 2'h1;
    localparam logic [1:0]  GUARD_BOOT = 2'h2;
    localparam logic [12:0] HALF_LIMIT = 13'h1000;
    localparam logic [12:0] BOOT_LIMIT = 13'h0200;
    localparam logic [2:0]  CFG_RESET  = 3'h7;

    typedef struct packed {
        logic [12:0] addr;
        logic        space;
        logic        erase;
        logic        prog;
        logic [13:0] wdata;
    } arr_req_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_READ  = 5'b00010,
        ST_ERASE = 5'b00100,
        ST_PROG  = 5'b01000,
        ST_WAIT  = 5'b10000
    } seq_state_t;

    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_HALF = 3'b010,
        KEY_OPEN = 3'b100
    } key_state_t;
endpackage

// ===== verilog/flash_array.sv
`timescale 1ns/1ps
module flash_array (
    input  wire logic        sys_clk_in,
    input  flash_self_program_pkg::arr_req_t req_in,
    input  wire logic [12:0] fetch_addr_in,
    output logic [13:0]      rd_word_out,
    output logic [13:0]      fetch_word_out
);
    import flash_self_program_pkg::*;

    // contents are undefined until software erases the row
    logic [13:0] pfm_mem [PFM_WORDS];
    logic [13:0] id_mem  [ID_WRITABLE];

    // erase is a whole row of ones; programming can only pull bits low
    always_ff @(posedge sys_clk_in) begin
        if (req_in.erase) begin
            for (int i = 0; i < ROW_WORDS; i++) begin
                if (req_in.space) begin
                    if (i < ID_WRITABLE) begin
                        id_mem[i] <= ERASED_WORD;
                    end
                end else begin
                    pfm_mem[{req_in.addr[12:5], i[4:0]}] <= ERASED_WORD;
                end
            end
        end else if (req_in.prog) begin
            if (req_in.space) begin
                id_mem[req_in.addr[1:0]] <= id_mem[req_in.addr[1:0]] & req_in.wdata;
            end else begin
                pfm_mem[req_in.addr] <= pfm_mem[req_in.addr] & req_in.wdata;
            end
        end
    end

    // 14-bit words, read without latency
    assign rd_word_out    = req_in.space ? id_mem[req_in.addr[1:0]] : pfm_mem[req_in.addr];
    assign fetch_word_out = pfm_mem[fetch_addr_in];
endmodule

// ===== dv/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic        sys_clk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    output logic             hsel_out,
    output logic      [31:0] haddr_out,
    output logic      [1:0]  htrans_out,
    output logic             hwrite_out,
    output logic      [2:0]  hsize_out,
    output logic      [31:0] hwdata_out
);
    // bus idle until the first transfer
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h0;
        hwdata_out = 32'h0;
    end
    // one word transfer; each phase held until hready is seen high, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_in);
        hsel_out <= 1'b1;
        haddr_out <= {24'h0, a};
        htrans_out <= 2'h2;
        hwrite_out <= w;
        hsize_out <= 3'h2; // whole word only
        do @(posedge sys_clk_in); while (hready_in !== 1'b1);
        htrans_out <= 2'h0;
        hwdata_out <= d;
        do @(posedge sys_clk_in); while (hready_in !== 1'b1);
        q = hrdata_in;
        hwdata_out <= ~d; // released data must not keep showing the last value
    endtask
endmodule

// ===== dv/flash_self_program_ctrl_tb.sv
`timescale 1ns/1ps
module flash_self_program_ctrl_tb;
    import flash_self_program_pkg::*;
    localparam logic [13:0] DEV_ID = 14'h0A5C; // arbitrary value
    localparam int C_W = (1 << CTRL_WR_BIT) | (1 << CTRL_MODIFY_ENABLE_BIT);
    logic        sys_clk_in, resetn_in, hsel, hwrite, hready, hresp, cp_n, ind_req, ind_valid, stall, irq, blk;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans, guard;
    logic [2:0]  hsize;
    logic [12:0] fa, ia, row;
    logic [13:0] fw, w, d1, d2;
    logic [7:0]  ib;
    int          n_errors, total_checks, seed, n;
    flash_self_program_ctrl #(.PROG_WAIT_CYCLES(20), .DEVICE_CODE(DEV_ID)) DUT (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .code_protect_n_in(cp_n), .self_update_guard_range_in(guard), .fetch_addr_in(fa),
        .fetch_word_out(fw), .ind_req_in(ind_req), .ind_addr_in(ia), .ind_byte_out(ib),
        .ind_valid_out(ind_valid), .cpu_stall_out(stall), .flash_done_irq_out(irq), .ext_access_block_out(blk));
    cpu_bus_model cpu (.sys_clk_in(sys_clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // programming only clears bits, so a reprogrammed word is the and of both
    function automatic logic [13:0] prog_word(input logic [13:0] old_w, input logic [13:0] new_w);
        return old_w & new_w;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cpu.xfer(1'b1, a, d, q);
    endtask
    // ctrl write, then count stall cycles under a bound
    task automatic op(input logic [31:0] c);
        wr(OFS_CTRL, c);
        #1;
        for (n = 0; stall !== 1'b0 && n < 500; n++) @(posedge sys_clk_in);
        chk(32'(n < 500), 32'h1);
    endtask
    task automatic ld(input logic [12:0] a, input logic [13:0] d);
        wr(OFS_ADDR_LO, {24'h0, a[7:0]});
        wr(OFS_ADDR_HI, {27'h0, a[12:8]});
        wr(OFS_WORD_LO, {24'h0, d[7:0]});
        wr(OFS_WORD_HI, {26'h0, d[13:8]});
    endtask
    // key pair must come straight before the strobe write
    task automatic go(input logic [31:0] c);
        wr(OFS_KEY, {24'h0, KEY_FIRST});
        wr(OFS_KEY, {24'h0, KEY_SECOND});
        op(c);
    endtask
    task automatic rdw(input logic sp, input logic [12:0] a, output logic [13:0] r);
        logic [31:0] lo;
        ld(a, 14'h0);
        op((1 << CTRL_RD_BIT) | (32'(sp) << CTRL_SPACE_BIT));
        cpu.xfer(1'b0, OFS_WORD_LO, 32'h0, lo);
        cpu.xfer(1'b0, OFS_WORD_HI, 32'h0, q);
        r = {q[5:0], lo[7:0]};
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the expected run
    initial begin
        #100000;
        n_errors++;
        report_and_stop;
    end
    initial begin
        {n_errors, total_checks, seed} = {32'd0, 32'd0, 32'd5229};
        {resetn_in, cp_n, guard, ind_req, ia, fa} = {1'b0, 1'b1, 2'h3, 1'b0, 26'h0};
        repeat (12) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        cpu.xfer(1'b0, OFS_CFG, 32'h0, q);
        chk(q, 32'h7);
        rdw(1'b1, {8'h0, ID_DEV_IDX}, w);
        chk(w, DEV_ID);
        cpu.xfer(1'b0, OFS_CTRL, 32'h0, q);
        chk(q[CTRL_RD_BIT], 1'b0);
        row = 13'($random(seed)) & 13'h1FE0;
        d1 = 14'($random(seed));
        d2 = 14'($random(seed));
        // row erase, then a partial row programmed from two latches
        ld(row, 14'h0);
        go(C_W | (1 << CTRL_FREE_BIT));
        chk(n >= 20, 1'b1);
        cpu.xfer(1'b0, OFS_CTRL, 32'h0, q);
        chk(q[CTRL_DONE_BIT], 1'b1);
        rdw(1'b0, row, w);
        chk(w, ERASED_WORD);
        ld(row, d1);
        go(C_W | (1 << CTRL_LOAD_BIT));
        ld(row + 13'd31, d2);
        go(C_W | (1 << CTRL_LOAD_BIT));
        go(C_W | (1 << CTRL_IE_BIT));
        chk({n >= 50, irq}, 2'b11);
        rdw(1'b0, row + 13'd31, w);
        chk({irq, w}, {1'b0, d2});
        rdw(1'b0, row + 13'd1, w);
        chk(w, ERASED_WORD);
        ld(row, d2);
        go(C_W | (1 << CTRL_LOAD_BIT));
        wr(OFS_KEY, {24'h0, KEY_FIRST});
        wr(OFS_KEY, {24'h0, KEY_SECOND});
        wr(OFS_CTRL, C_W);
        // a strobe with irq enable set while busy must be dropped
        op((1 << CTRL_RD_BIT) | (1 << CTRL_IE_BIT));
        chk(irq, 1'b0);
        rdw(1'b0, row, w);
        chk(w, prog_word(d1, d2));
        // indirect byte read and fetch of the same word
        fa <= row + 13'd31;
        @(posedge sys_clk_in);
        ind_req <= 1'b1;
        ia <= row + 13'd31;
        @(posedge sys_clk_in);
        ind_req <= 1'b0;
        #1;
        chk({stall, ind_valid, ib, fw}, {2'b11, d2[7:0], d2});
        // whole array guarded: erase must be skipped
        guard <= 2'h0;
        repeat (4) @(posedge sys_clk_in);
        ld(row, 14'h0);
        go(C_W | (1 << CTRL_FREE_BIT));
        cpu.xfer(1'b0, OFS_CTRL, 32'h0, q);
        chk({31'h0, q[CTRL_WR_BIT]}, 32'h0);
        chk(n, 32'h0);
        rdw(1'b0, row + 13'd31, w);
        chk(w, d2);
        cp_n <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        chk({blk, hresp}, 2'b10);
        report_and_stop;
    end
endmodule
